// *** servo_command_gear_scaling.sv ***
// command input stage: mode forcing and electronic gear scaling
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "servo_gear_params.svh"
// Notes on behaviour
// - A command is a position command in position and full-closed mode, speed in velocity, torque in torque.
// - An internally forced mode replaces the host mode while the drive status asks for one.
// - Position loop analysis forces position mode and velocity loop analysis forces velocity mode.
// - Torque speed analysis forces position, velocity or torque mode for automatic, vertical, normal.
// - A tool driven trial run forces position mode.
// - Forced-position stop functions and retracting force position mode.
// - Position and speed commands are multiplied by the gear ratio in every mode.
// - Outside full-closed mode a nonzero pulses per revolution gives encoder resolution over that value, ignoring the others.
// - Full-closed mode ignores pulses per revolution and uses only numerator and denominator.
// - Outside full-closed with pulses zero and numerator nonzero the ratio is numerator over denominator.
// - Full-closed mode with a zero numerator uses a ratio of one.
// - Full-closed mode with a nonzero numerator uses numerator over denominator.
// - A ratio outside one thousandth to 128000 raises parameter setup error one.
// - Numerator accepts 0 to 1073741824 and denominator 1 to 1073741824, else an error; a zero denominator is flagged only where the ratio uses it.
module servo_command_gear_scaling #(
   parameter logic [31:0] ENC_RES = `ENC_RES_DEF
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [31:0] reg_rdata_o,
   // host command
   input wire logic cmd_valid_i,
   input wire servo_gear_pkg::mode_t cmd_mode_i,
   input wire logic [31:0] cmd_value_i,
   // internal operating status
   input wire logic ana_pos_i,
   input wire logic ana_vel_i,
   input wire logic ana_trq_i,
   input wire servo_gear_pkg::variant_t variant_i,
   input wire logic trial_run_i,
   input wire logic decel_pos_i,
   input wire logic retract_i,
   // commands to the controllers
   output logic [31:0] pos_cmd_o,
   output logic pos_valid_o,
   output logic [31:0] vel_cmd_o,
   output logic vel_valid_o,
   output logic [31:0] trq_cmd_o,
   output logic trq_valid_o,
   // status
   output servo_gear_pkg::mode_t active_mode_o,
   output logic mode_forced_o,
   output logic cmd_busy_o,
   output logic param_err_o,
   output logic irq_o
);
   import servo_gear_pkg::*;

   mode_t host_mode_q;
   mode_t arb_in;
   mode_t arb_mode;
   logic arb_forced;
   logic [31:0] ppr_q;
   logic [31:0] num_q;
   logic [31:0] den_q;
   logic [`IRQ_W-1:0] irq_stat_q;
   logic [`IRQ_W-1:0] irq_mask_q;
   logic [`IRQ_W-1:0] irq_set;
   logic [31:0] num_eff;
   logic [31:0] den_eff;
   logic ratio_ok;
   logic raw_ok;
   logic gear_wr;
   seq_t seq_q;
   logic accept;
   logic [31:0] val_q;
   logic is_vel_q;
   logic [31:0] num_l_q;
   logic [31:0] den_l_q;
   logic neg_q;
   logic [31:0] rem_pos_q;
   logic [31:0] rem_vel_q;
   logic [31:0] rem_sel;
   logic signed [64:0] acc;
   logic signed [64:0] mag_s;
   logic div_start;
   logic div_done;
   logic [63:0] div_quot;
   logic [31:0] div_rem;
   logic [63:0] qfix;
   logic [31:0] rfix;

   // host mode sticks until the next command names another
   always_comb arb_in = cmd_valid_i ? cmd_mode_i : host_mode_q;

   gear_mode_arbiter u_arb (
      .host_mode_i(arb_in),
      .ana_pos_i(ana_pos_i),
      .ana_vel_i(ana_vel_i),
      .ana_trq_i(ana_trq_i),
      .variant_i(variant_i),
      .trial_run_i(trial_run_i),
      .decel_pos_i(decel_pos_i),
      .retract_i(retract_i),
      .mode_o(arb_mode),
      .forced_o(arb_forced)
   );

   // mode tracking; host mode recorded but overridden while forced
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         host_mode_q <= MODE_POS;
         active_mode_o <= MODE_POS;
         mode_forced_o <= 1'b0;
      end else begin
         if (cmd_valid_i) begin
            host_mode_q <= cmd_mode_i;
         end
         active_mode_o <= arb_mode;
         mode_forced_o <= arb_forced;
      end
   end

   // effective ratio from the three settings and the mode
   always_comb begin
      num_eff = num_q;
      den_eff = den_q;
      if (arb_mode == MODE_FC) begin
         if (num_q == 32'h0) begin
            num_eff = 32'h1;
            den_eff = 32'h1;
         end else begin
            num_eff = num_q;
            den_eff = den_q;
         end
      end else if (ppr_q != 32'h0) begin
         num_eff = ENC_RES;
         den_eff = ppr_q;
      end else if (num_q == 32'h0) begin
         num_eff = ENC_RES;
         den_eff = den_q;
      end else begin
         num_eff = num_q;
         den_eff = den_q;
      end
   end

   // window check in 64 bits so the products cannot wrap
   always_comb begin
      raw_ok = (ppr_q <= `PPR_MAX) && (num_q <= `NUM_MAX) && (den_q <= `NUM_MAX);
      ratio_ok = raw_ok && (den_eff != 32'h0) && (num_eff != 32'h0)
         && ({32'h0, den_eff} <= {32'h0, num_eff} * `RATIO_MIN_DIV)
         && ({32'h0, num_eff} <= {32'h0, den_eff} * `RATIO_MAX_MUL);
   end

   always_comb gear_wr = reg_we_i && ((reg_addr_i == `OFS_PPR)
      || (reg_addr_i == `OFS_NUM) || (reg_addr_i == `OFS_DEN));

   // gear settings; out-of-range values are kept and flagged
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ppr_q <= `RST_PPR;
         num_q <= `RST_NUM;
         den_q <= `RST_DEN;
      end else if (reg_we_i) begin
         case (reg_addr_i)
            `OFS_PPR: ppr_q <= reg_wdata_i;
            `OFS_NUM: num_q <= reg_wdata_i;
            `OFS_DEN: den_q <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   // error flag follows the settings
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         param_err_o <= 1'b0;
      end else begin
         param_err_o <= !ratio_ok;
      end
   end

   // events: error rising and entry into a forced mode
   always_comb begin
      irq_set = '0;
      irq_set[`IRQ_ERR_BIT] = !ratio_ok && !param_err_o;
      irq_set[`IRQ_FORCE_BIT] = arb_forced && !mode_forced_o;
   end

   // sticky status, write one to clear; a set in the clear cycle wins
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_stat_q <= '0;
         irq_mask_q <= `RST_MASK;
      end else begin
         if (reg_we_i && reg_addr_i == `OFS_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~reg_wdata_i[`IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         if (reg_we_i && reg_addr_i == `OFS_IRQ_MASK) begin
            irq_mask_q <= reg_wdata_i[`IRQ_W-1:0];
         end
      end
   end

   // level interrupt, one cycle behind the status
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_q & irq_mask_q);
      end
   end

   // read data in the cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         reg_rdata_o <= 32'h0;
      end else if (reg_re_i) begin
         case (reg_addr_i)
            `OFS_PPR: reg_rdata_o <= ppr_q;
            `OFS_NUM: reg_rdata_o <= num_q;
            `OFS_DEN: reg_rdata_o <= den_q;
            `OFS_STAT: reg_rdata_o <= {25'h0, cmd_busy_o, param_err_o, mode_forced_o,
               active_mode_o};
            `OFS_IRQ_STAT: reg_rdata_o <= {30'h0, irq_stat_q};
            `OFS_IRQ_MASK: reg_rdata_o <= {30'h0, irq_mask_q};
            default: reg_rdata_o <= 32'h0;
         endcase
      end else begin
         reg_rdata_o <= 32'h0;
      end
   end

   always_comb accept = cmd_valid_i && (seq_q == ST_IDLE);

   // sign and magnitude of command times numerator plus carried remainder
   always_comb begin
      rem_sel = is_vel_q ? rem_vel_q : rem_pos_q;
      acc = $signed(val_q) * $signed({1'b0, num_l_q}) + $signed({33'h0, rem_sel});
      mag_s = acc[64] ? -acc : acc;
   end

   // floor division for negative values keeps the remainder positive
   always_comb begin
      if (neg_q && div_rem != 32'h0) begin
         qfix = ~div_quot;
         rfix = den_l_q - div_rem;
      end else if (neg_q) begin
         qfix = ~div_quot + 64'h1;
         rfix = 32'h0;
      end else begin
         qfix = div_quot;
         rfix = div_rem;
      end
   end

   // the divider loads in the multiply cycle, so it takes the product straight from the adder;
   // a registered copy would only be written on that same edge and start it on stale data
   always_comb div_start = (seq_q == ST_MUL);

   gear_divider #(
      .DW(64),
      .SW(32)
   ) u_div (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .start_i(div_start),
      .dividend_i(mag_s[63:0]),
      .divisor_i(den_l_q),
      .done_o(div_done),
      .quot_o(div_quot),
      .rem_o(div_rem)
   );

   // command sequencer; commands while busy, and geared commands in error, are dropped
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         seq_q <= ST_IDLE;
         cmd_busy_o <= 1'b0;
         val_q <= 32'h0;
         is_vel_q <= 1'b0;
         num_l_q <= 32'h1;
         den_l_q <= 32'h1;
         neg_q <= 1'b0;
      end else begin
         case (seq_q)
            ST_IDLE: begin
               if (accept && arb_mode != MODE_TRQ && ratio_ok) begin
                  val_q <= cmd_value_i;
                  is_vel_q <= (arb_mode == MODE_VEL);
                  num_l_q <= num_eff;
                  den_l_q <= den_eff;
                  seq_q <= ST_MUL;
                  cmd_busy_o <= 1'b1;
               end
            end
            ST_MUL: begin
               neg_q <= acc[64];
               seq_q <= ST_DIV;
            end
            ST_DIV: begin
               if (div_done) begin
                  seq_q <= ST_IDLE;
                  cmd_busy_o <= 1'b0;
               end
            end
            default: begin
               seq_q <= ST_IDLE;
               cmd_busy_o <= 1'b0;
            end
         endcase
      end
   end

   // scaled outputs; the low 32 bits wrap like the host position count
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pos_cmd_o <= 32'h0;
         vel_cmd_o <= 32'h0;
         pos_valid_o <= 1'b0;
         vel_valid_o <= 1'b0;
      end else begin
         pos_valid_o <= 1'b0;
         vel_valid_o <= 1'b0;
         if (seq_q == ST_DIV && div_done) begin
            if (is_vel_q) begin
               vel_cmd_o <= qfix[31:0];
               vel_valid_o <= 1'b1;
            end else begin
               pos_cmd_o <= qfix[31:0];
               pos_valid_o <= 1'b1;
            end
         end
      end
   end

   // remainders restart whenever the ratio settings change
   always_ff @(posedge core_clk_i) begin
      if (rst_i || gear_wr) begin
         rem_pos_q <= 32'h0;
         rem_vel_q <= 32'h0;
      end else if (seq_q == ST_DIV && div_done) begin
         if (is_vel_q) begin
            rem_vel_q <= rfix;
         end else begin
            rem_pos_q <= rfix;
         end
      end
   end

   // torque commands bypass the gear
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         trq_cmd_o <= 32'h0;
         trq_valid_o <= 1'b0;
      end else begin
         trq_valid_o <= accept && arb_mode == MODE_TRQ;
         if (accept && arb_mode == MODE_TRQ) begin
            trq_cmd_o <= cmd_value_i;
         end
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   AST_TRQ_PASS: assert property ((accept && arb_mode == MODE_TRQ) |=>
      (trq_valid_o && trq_cmd_o == $past(cmd_value_i)))
      else $error("torque command not passed");
   AST_HOST_MODE: assert property ((cmd_valid_i && !arb_forced) |=>
      (active_mode_o == $past(cmd_mode_i) && !mode_forced_o))
      else $error("host mode not followed");
   AST_ANA_POS: assert property (ana_pos_i |=> (active_mode_o == MODE_POS && mode_forced_o))
      else $error("position analysis not forced");
   AST_ANA_VEL: assert property ((!ana_pos_i && ana_vel_i) |=> active_mode_o == MODE_VEL)
      else $error("velocity analysis not forced");
   AST_TRQ_VAR: assert property ((!ana_pos_i && !ana_vel_i && ana_trq_i && variant_i == VAR_VERT)
      |=> active_mode_o == MODE_VEL)
      else $error("vertical variant not forced");
   AST_TRIAL: assert property ((!ana_pos_i && !ana_vel_i && !ana_trq_i
      && (trial_run_i || retract_i || decel_pos_i)) |=> active_mode_o == MODE_POS)
      else $error("trial or stop not forced to position");
   AST_LATENCY: assert property ((accept && arb_mode != MODE_TRQ && ratio_ok) |=>
      (!pos_valid_o && !vel_valid_o)[*8] ##[59:59] (pos_valid_o || vel_valid_o))
      else $error("scaled command latency wrong");
   AST_PPR_SEL: assert property ((arb_mode != MODE_FC && ppr_q != 32'h0) |->
      (num_eff == ENC_RES && den_eff == ppr_q))
      else $error("pulses per revolution not used");
   AST_FC_UNITY: assert property ((arb_mode == MODE_FC && num_q == 32'h0) |->
      (num_eff == 32'h1 && den_eff == 32'h1))
      else $error("full-closed unity ratio missing");
   AST_ERR_IRQ: assert property ($rose(param_err_o) |-> irq_stat_q[`IRQ_ERR_BIT])
      else $error("error event not latched");
   AST_REM_BOUND: assert property ($rose(pos_valid_o) |-> rem_pos_q < den_l_q)
      else $error("carried remainder out of range");

   COV_FORCED_POS: cover property (trial_run_i && accept && cmd_mode_i == MODE_VEL);
   COV_TRQ: cover property (trq_valid_o);
   COV_ERR: cover property ($rose(param_err_o));
   COV_NEG_POS: cover property (pos_valid_o && pos_cmd_o[31]);
endmodule : servo_command_gear_scaling
`default_nettype wire

// *** servo_gear_params.svh ***
// register offsets, reset values and limits of the command gear stage
`ifndef SERVO_GEAR_PARAMS_SVH
`define SERVO_GEAR_PARAMS_SVH
// byte offsets on the register port
`define OFS_PPR 8'h00
`define OFS_NUM 8'h04
`define OFS_DEN 8'h08
`define OFS_STAT 8'h0C
`define OFS_IRQ_STAT 8'h10
`define OFS_IRQ_MASK 8'h14
// reset values give a unity gear
`define RST_PPR 32'h00000000
`define RST_NUM 32'h00000001
`define RST_DEN 32'h00000001
`define RST_MASK 2'h0
// accepted setting ranges
`define PPR_MAX 32'h08000000
`define NUM_MAX 32'h40000000
// gear ratio window: 1/1000 up to 128000
`define RATIO_MIN_DIV 64'h00000000000003E8
`define RATIO_MAX_MUL 64'h000000000001F400
// encoder counts per revolution
`define ENC_RES_DEF 32'h08000000
// interrupt status bit positions
`define IRQ_ERR_BIT 0
`define IRQ_FORCE_BIT 1
`define IRQ_W 2
// status register field positions
`define STAT_FORCED_BIT 4
`define STAT_ERR_BIT 5
`define STAT_BUSY_BIT 6
`endif

// *** servo_gear_pkg.sv ***
// types shared by the command gear stage
package servo_gear_pkg;
   // control modes, one-hot
   typedef enum logic [3:0] {
      MODE_POS = 4'h1,
      MODE_VEL = 4'h2,
      MODE_TRQ = 4'h4,
      MODE_FC  = 4'h8
   } mode_t;
   // torque speed analysis variants
   typedef enum logic [2:0] {
      VAR_AUTO = 3'h1,
      VAR_VERT = 3'h2,
      VAR_NORM = 3'h4
   } variant_t;
   // command sequencer
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_MUL  = 3'h2,
      ST_DIV  = 3'h4
   } seq_t;
   // divider states
   typedef enum logic [1:0] {
      DV_IDLE = 2'h1,
      DV_RUN  = 2'h2
   } div_st_t;
endpackage : servo_gear_pkg

// *** gear_mode_arbiter.sv ***
// picks the control mode from host request and internal operating status
`timescale 1ns/100ps
`default_nettype none
module gear_mode_arbiter (
   // host request
   input wire servo_gear_pkg::mode_t host_mode_i,
   // internal operating status
   input wire logic ana_pos_i,
   input wire logic ana_vel_i,
   input wire logic ana_trq_i,
   input wire servo_gear_pkg::variant_t variant_i,
   input wire logic trial_run_i,
   input wire logic decel_pos_i,
   input wire logic retract_i,
   // result
   output servo_gear_pkg::mode_t mode_o,
   output logic forced_o
);
   import servo_gear_pkg::*;

   // analysis outranks trial run, which outranks stop functions
   always_comb begin
      mode_o = host_mode_i;
      forced_o = 1'b1;
      if (ana_pos_i) begin
         mode_o = MODE_POS;
      end else if (ana_vel_i) begin
         mode_o = MODE_VEL;
      end else if (ana_trq_i) begin
         case (variant_i)
            VAR_AUTO: mode_o = MODE_POS;
            VAR_VERT: mode_o = MODE_VEL;
            VAR_NORM: mode_o = MODE_TRQ;
            default: mode_o = MODE_TRQ;
         endcase
      end else if (trial_run_i) begin
         mode_o = MODE_POS;
      end else if (decel_pos_i || retract_i) begin
         mode_o = MODE_POS;
      end else begin
         forced_o = 1'b0;
      end
   end
endmodule : gear_mode_arbiter
`default_nettype wire

// *** gear_divider.sv ***
// restoring divider, one quotient bit per clock
`timescale 1ns/100ps
`default_nettype none
module gear_divider #(
   parameter int DW = 64,
   parameter int SW = 32
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // operands
   input wire logic start_i,
   input wire logic [DW-1:0] dividend_i,
   input wire logic [SW-1:0] divisor_i,
   // results
   output logic done_o,
   output logic [DW-1:0] quot_o,
   output logic [SW-1:0] rem_o
);
   import servo_gear_pkg::*;

   div_st_t st_q;
   logic [SW-1:0] div_q;
   logic [SW:0] shifted;
   logic [SW:0] diff;
   logic [$clog2(DW)-1:0] cnt_q;
   logic take;

   // shift in next dividend bit and try the subtraction
   always_comb begin
      shifted = {rem_o, quot_o[DW-1]};
      diff = shifted - {1'b0, div_q};
      take = shifted >= {1'b0, div_q};
   end

   // quotient shifts left as bits are decided; start ignored while running
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_q <= DV_IDLE;
         quot_o <= '0;
         rem_o <= '0;
         div_q <= '0;
         cnt_q <= '0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         case (st_q)
            DV_IDLE: begin
               if (start_i) begin
                  quot_o <= dividend_i;
                  rem_o <= '0;
                  div_q <= divisor_i;
                  cnt_q <= '0;
                  st_q <= DV_RUN;
               end
            end
            DV_RUN: begin
               quot_o <= {quot_o[DW-2:0], take};
               rem_o <= take ? diff[SW-1:0] : shifted[SW-1:0];
               cnt_q <= cnt_q + 1'b1;
               if (&cnt_q) begin
                  done_o <= 1'b1;
                  st_q <= DV_IDLE;
               end
            end
            default: st_q <= DV_IDLE;
         endcase
      end
   end
endmodule : gear_divider
`default_nettype wire

// *** host_cmd_model.sv ***
// host controller model that issues one command per request
`timescale 1ns/100ps
`default_nettype none
module host_cmd_model (
   // clock
   input wire logic core_clk_i,
   // request from the bench
   input wire logic send_i,
   input wire servo_gear_pkg::mode_t mode_i,
   input wire logic [31:0] value_i,
   // command link
   output logic cmd_valid_o = 1'b0,
   output servo_gear_pkg::mode_t cmd_mode_o = servo_gear_pkg::MODE_POS,
   output logic [31:0] cmd_value_o = 32'h00000000
);
   import servo_gear_pkg::*;
   // one strobe per request; the value toggles outside it so stale data never matches
   // the value field is read by the active mode, so a forced mode reinterprets it
   always @(posedge core_clk_i) begin
      cmd_valid_o <= send_i;
      if (send_i) begin
         cmd_mode_o <= mode_i;
         cmd_value_o <= value_i;
      end else begin
         cmd_value_o <= ~cmd_value_o;
      end
   end
endmodule : host_cmd_model
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the command gear stage
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import servo_gear_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic we = 1'b0;
   logic re = 1'b0;
   logic send = 1'b0;
   mode_t smode = MODE_POS;
   logic [31:0] sval = 32'h00000000;
   logic [5:0] stat = 6'h00;
   variant_t vr = VAR_NORM;
   logic c_valid;
   mode_t c_mode;
   logic [31:0] c_value, rdata, pos_cmd, vel_cmd, trq_cmd;
   logic pos_v, vel_v, trq_v, forced, perr, irq, busy;
   mode_t amode;
   int failures = 0;
   int tests_run = 0;

   // small encoder resolution keeps the expected products readable
   servo_command_gear_scaling #(.ENC_RES(32'h00000400)) dut (
      .core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .cmd_valid_i(c_valid),
      .cmd_mode_i(c_mode), .cmd_value_i(c_value), .ana_pos_i(stat[5]), .ana_vel_i(stat[4]),
      .ana_trq_i(stat[3]), .variant_i(vr), .trial_run_i(stat[2]), .decel_pos_i(stat[1]),
      .retract_i(stat[0]), .pos_cmd_o(pos_cmd), .pos_valid_o(pos_v), .vel_cmd_o(vel_cmd),
      .vel_valid_o(vel_v), .trq_cmd_o(trq_cmd), .trq_valid_o(trq_v), .active_mode_o(amode),
      .mode_forced_o(forced), .cmd_busy_o(busy), .param_err_o(perr), .irq_o(irq));

   host_cmd_model host (
      .core_clk_i(clk), .send_i(send), .mode_i(smode), .value_i(sval),
      .cmd_valid_o(c_valid), .cmd_mode_o(c_mode), .cmd_value_o(c_value));

   // 10 MHz clock
   always #50 clk = ~clk;

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      re <= 1'b1;
      addr <= a;
      @(posedge clk);
      re <= 1'b0;
      #1;
      chk(rdata, e);
   endtask : rd

   // sel picks position, speed or torque output; want=0 expects the command dropped
   task automatic cmd(input mode_t m, input logic [31:0] v, input logic [31:0] e,
                      input int sel, input logic want);
      logic seen;
      seen = 1'b0;
      @(posedge clk);
      send <= 1'b1;
      smode <= m;
      sval <= v;
      @(posedge clk);
      send <= 1'b0;
      for (int n = 0; n < 90 && !seen; n++) begin
         @(posedge clk);
         #1;
         seen = (sel == 0) ? pos_v === 1'b1 : (sel == 1) ? vel_v === 1'b1 : trq_v === 1'b1;
         // only an accepted geared command keeps the stage busy after the accept edge
         if (n == 0) begin
            chk({31'h0, busy}, {31'h0, want && (sel != 2)});
         end
      end
      chk({31'h0, seen}, {31'h0, want});
      if (seen && want) begin
         chk((sel == 0) ? pos_cmd : (sel == 1) ? vel_cmd : trq_cmd, e);
      end
      repeat (2) @(posedge clk);
   endtask : cmd

   task automatic frc(input logic [5:0] s, input variant_t v, input mode_t e);
      @(posedge clk);
      stat <= s;
      vr <= v;
      repeat (3) @(posedge clk);
      #1;
      chk({28'h0, amode}, {28'h0, e});
      chk({31'h0, forced}, 32'h00000001);
   endtask : frc

   task report_and_stop;
      if (failures == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      report_and_stop();
   end

   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(8'h00, 32'h00000000);
      rd(8'h04, 32'h00000001);
      rd(8'h08, 32'h00000001);
      rd(8'h14, 32'h00000000);
      rd(8'h20, 32'h00000000);
      cmd(MODE_POS, 32'h00000005, 32'h00000005, 0, 1'b1);
      cmd(MODE_TRQ, 32'h00000009, 32'h00000009, 2, 1'b1);
      cmd(MODE_VEL, 32'h00000006, 32'h00000006, 1, 1'b1);
      wr(8'h00, 32'h00000100);
      wr(8'h04, 32'h00000003);
      cmd(MODE_POS, 32'h00000003, 32'h0000000C, 0, 1'b1);
      cmd(MODE_VEL, 32'h00000002, 32'h00000008, 1, 1'b1);
      wr(8'h00, 32'h00000000);
      wr(8'h04, 32'h00000000);
      wr(8'h08, 32'h00000008);
      cmd(MODE_POS, 32'h00000002, 32'h00000100, 0, 1'b1);
      wr(8'h04, 32'h00000003);
      wr(8'h08, 32'h00000002);
      cmd(MODE_POS, 32'h00000003, 32'h00000004, 0, 1'b1);
      cmd(MODE_POS, 32'h00000003, 32'h00000005, 0, 1'b1);
      wr(8'h00, 32'h00000100);
      wr(8'h04, 32'h00000000);
      cmd(MODE_FC, 32'h00000007, 32'h00000007, 0, 1'b1);
      wr(8'h04, 32'h00000003);
      cmd(MODE_FC, 32'h00000003, 32'h00000004, 0, 1'b1);
      // ratio just below one thousandth, interrupt unmasked
      wr(8'h14, 32'h00000003);
      wr(8'h00, 32'h00000000);
      wr(8'h04, 32'h00000001);
      wr(8'h08, 32'h000003E9);
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, perr}, 32'h00000001);
      chk({31'h0, irq}, 32'h00000001);
      rd(8'h10, 32'h00000001);
      cmd(MODE_POS, 32'h00000005, 32'h00000000, 0, 1'b0);
      cmd(MODE_TRQ, 32'h00000008, 32'h00000008, 2, 1'b1);
      wr(8'h08, 32'h00000001);
      wr(8'h10, 32'h00000001);
      rd(8'h10, 32'h00000000);
      #1;
      chk({31'h0, perr}, 32'h00000000);
      chk({31'h0, irq}, 32'h00000000);
      wr(8'h04, 32'h40000001);
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, perr}, 32'h00000001);
      wr(8'h04, 32'h00000001);
      frc(6'b100000, VAR_NORM, MODE_POS);
      frc(6'b010000, VAR_NORM, MODE_VEL);
      frc(6'b001000, VAR_AUTO, MODE_POS);
      frc(6'b001000, VAR_VERT, MODE_VEL);
      frc(6'b001000, VAR_NORM, MODE_TRQ);
      frc(6'b000100, VAR_NORM, MODE_POS);
      frc(6'b000010, VAR_NORM, MODE_POS);
      frc(6'b000001, VAR_NORM, MODE_POS);
      frc(6'b010000, VAR_NORM, MODE_VEL);
      rd(8'h0C, 32'h00000012);
      rd(8'h10, 32'h00000003);
      cmd(MODE_TRQ, 32'h00000004, 32'h00000004, 1, 1'b1);
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
